// *** svcp_pkg.sv ***
// Shared constants, types and register map of the servo command pulse I/O block.
package svcp_pkg;

    // ==========================================================================
    // Register map (byte addresses, one 32-bit word each)
    // ==========================================================================
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam logic [7:0]  OFS_CTRL          = 8'h00;
    localparam logic [7:0]  OFS_INPOS_WINDOW  = 8'h04;
    localparam logic [7:0]  OFS_OVF_LIMIT     = 8'h08;
    localparam logic [7:0]  OFS_BRAKE_DELAY   = 8'h0C;
    localparam logic [7:0]  OFS_DEVIATION     = 8'h10;
    localparam logic [7:0]  OFS_STATE         = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK      = 8'h1C;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int          CTRL_FMT_LSB      = 0;
    localparam int          CTRL_FMT_W        = 3;
    localparam int          CTRL_TX_BIT       = 4;
    localparam int          ST_SERVO_ON_BIT   = 0;
    localparam int          ST_ALARM_BIT      = 1;
    localparam int          ST_INPOS_BIT      = 2;
    localparam int          ST_BRAKE_BIT      = 3;
    localparam int          ST_RX_BIT         = 4;
    localparam int          ST_CLEAR_BIT      = 5;
    localparam int          EV_ALARM          = 0;
    localparam int          EV_SHORT_CLEAR    = 1;
    localparam int          EV_RATE_HIGH      = 2;
    localparam int          EV_INDEX          = 3;
    localparam int          EV_INPOS_ENTER    = 4;
    localparam int          EV_W              = 5;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic [2:0]  RST_FORMAT        = 3'h0;
    localparam logic [31:0] RST_INPOS_WINDOW  = 32'h0000_000A;
    localparam logic [31:0] RST_OVF_LIMIT     = 32'h0001_0000;
    localparam logic [31:0] RST_BRAKE_DELAY   = 32'h0000_4E20;
    localparam logic [EV_W-1:0] RST_IRQ_MASK  = 5'h00;

    // ==========================================================================
    // Command pulse formats
    // ==========================================================================
    localparam logic [2:0]  FMT_PULSE_DIR     = 3'h0;
    localparam logic [2:0]  FMT_FWD_REV       = 3'h1;
    localparam logic [2:0]  FMT_QUAD_X1       = 3'h2;
    localparam logic [2:0]  FMT_QUAD_X2       = 3'h3;
    localparam logic [2:0]  FMT_QUAD_X4       = 3'h4;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int          CLK_MHZ           = 200;
    localparam int          MAX_RATE_KPPS     = 250;
    localparam int          CLEAR_MIN_US      = 20;
    // Least spacing of command pulses, rounded up to whole cycles.
    localparam int          RATE_MIN_CYC      = (CLK_MHZ * 1000 + MAX_RATE_KPPS - 1)
                                                / MAX_RATE_KPPS;
    localparam int          CLEAR_MIN_CYC     = CLEAR_MIN_US * CLK_MHZ;
    localparam int          TIMER_W           = 16;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef struct packed {
        logic a;
        logic b;
    } svcp_pair_type;

    typedef struct packed {
        logic step;
        logic fwd;
    } svcp_step_type;

    typedef enum logic [1:0] {
        SV_OFF,
        SV_RELEASE,
        SV_ON
    } svcp_servo_type;

endpackage : svcp_pkg

// *** svcp_step_decode.sv ***
// Decodes a two-line pulse input into single-cycle counting steps with direction.
`timescale 1ns/1ps
module svcp_step_decode
    import svcp_pkg::*;
(
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_ce,
    // Pulse lines and format
    input  wire svcp_pair_type i_pins,
    input  wire logic [2:0]    i_format,
    input  wire logic          i_block,
    // Decoded step
    output svcp_step_type      o_step
);

    svcp_pair_type prev_reg;
    logic          a_rise;
    logic          b_rise;
    logic          a_edge;
    logic          b_edge;
    svcp_step_type step_next;

    assign a_rise = i_pins.a & ~prev_reg.a;
    assign b_rise = i_pins.b & ~prev_reg.b;
    assign a_edge = i_pins.a ^ prev_reg.a;
    assign b_edge = i_pins.b ^ prev_reg.b;

    always_comb begin
        step_next = '0;
        case (i_format)
            FMT_PULSE_DIR: begin
                step_next = '{step: a_rise, fwd: i_pins.b};
            end
            FMT_FWD_REV: begin
                step_next = '{step: a_rise ^ b_rise, fwd: b_rise};
            end
            FMT_QUAD_X1: begin
                step_next = '{step: a_rise, fwd: ~i_pins.b};
            end
            FMT_QUAD_X2: begin
                step_next = '{step: a_edge, fwd: i_pins.a ^ i_pins.b};
            end
            FMT_QUAD_X4: begin
                if (a_edge && !b_edge) begin
                    step_next = '{step: 1'b1, fwd: i_pins.a ^ i_pins.b};
                end else if (b_edge && !a_edge) begin
                    step_next = '{step: 1'b1, fwd: ~(i_pins.a ^ i_pins.b)};
                end
            end
            default: begin
                step_next = '0;
            end
        endcase
        if (i_block) begin
            step_next = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            prev_reg <= '0;
            o_step   <= '0;
        end else if (i_ce) begin
            prev_reg <= i_pins;
            o_step   <= step_next;
        end
    end

endmodule : svcp_step_decode

// *** svcp_top.sv ***
// Servo command pulse I/O: pulse decoding, deviation counter and sequence outputs.
//
// Notes on behaviour
// - Command pulses up to 250 kpps are accepted; faster spacing is flagged.
// - Command lines decode as pulse/direction, forward/reverse, or quadrature.
// - Format 0 pulse/dir, 1 fwd/rev, 2/3/4 quadrature x1/x2/x4.
// - While deviation clear is high, pulses are ignored and deviation is zero.
// - Run input high with no latched alarm enters servo-on; removing it leaves servo-on.
// - Alarm reset input clears the latched alarm once no fault or over-limit condition is present.
// - Encoder index is repeated on the index output, one pulse per revolution.
// - Fault output is high in normal operation and low on alarm.
// - In-position output is high while deviation magnitude is within window.
// - Brake interlock output carries the holding brake timing.
// - Full-duplex serial receive and transmit lines are provided separately.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module svcp_top
    import svcp_pkg::*;
#(
    parameter int DEV_W = 24
)(
    // Clock, reset, enable
    input  wire logic              I_MCLK,
    input  wire logic              I_NRST,
    input  wire logic              I_CE,
    // Register port
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [DATA_W-1:0] I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic      [DATA_W-1:0] O_RDATA,
    output logic                   O_IRQ,
    // Command and sequence inputs
    input  wire logic              I_FEED_PULSE,
    input  wire logic              I_FORWARD_PULSE,
    input  wire logic              I_DEVIATION_CLEAR,
    input  wire logic              I_RUN,
    input  wire logic              I_ALARM_RESET,
    // Encoder and fault sources
    input  wire logic              I_ENC_A,
    input  wire logic              I_ENC_B,
    input  wire logic              I_ENC_INDEX,
    input  wire logic              I_FAULT_DETECT,
    // Sequence outputs
    output logic                   O_INDEX_PULSE_RETURN,
    output logic                   O_FAULT_OUT,
    output logic                   O_BRAKE_INTERLOCK,
    output logic                   O_IN_POSITION_OUT,
    output logic                   O_SERVO_ON,
    // Serial lines
    input  wire logic              I_SER_RX,
    output logic                   O_SER_TX
);

    // ==========================================================================
    // Register state
    // ==========================================================================
    logic [2:0]              format_reg;
    logic                    tx_level_reg;
    logic [DATA_W-1:0]       inpos_window_reg;
    logic [DATA_W-1:0]       ovf_limit_reg;
    logic [DATA_W-1:0]       brake_delay_reg;
    logic [EV_W-1:0]         irq_status_reg;
    logic [EV_W-1:0]         irq_mask_reg;
    logic [EV_W-1:0]         events;
    logic                    wr_en;
    logic                    rd_en;

    assign wr_en = I_WR & I_CE;
    assign rd_en = I_RD & I_CE;

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            format_reg       <= RST_FORMAT;
            tx_level_reg     <= 1'b1;
            inpos_window_reg <= RST_INPOS_WINDOW;
            ovf_limit_reg    <= RST_OVF_LIMIT;
            brake_delay_reg  <= RST_BRAKE_DELAY;
            irq_mask_reg     <= RST_IRQ_MASK;
        end else if (wr_en) begin
            case (I_ADDR)
                OFS_CTRL: begin
                    format_reg   <= I_WDATA[CTRL_FMT_LSB +: CTRL_FMT_W];
                    tx_level_reg <= I_WDATA[CTRL_TX_BIT];
                end
                OFS_INPOS_WINDOW: begin
                    inpos_window_reg <= I_WDATA;
                end
                OFS_OVF_LIMIT: begin
                    ovf_limit_reg <= I_WDATA;
                end
                OFS_BRAKE_DELAY: begin
                    brake_delay_reg <= I_WDATA;
                end
                OFS_IRQ_MASK: begin
                    irq_mask_reg <= I_WDATA[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================================
    // Input capture
    // ==========================================================================
    logic clear_reg;
    logic index_reg;
    logic rx_reg;

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            clear_reg <= 1'b0;
            index_reg <= 1'b0;
            rx_reg    <= 1'b1;
        end else if (I_CE) begin
            clear_reg <= I_DEVIATION_CLEAR;
            index_reg <= I_ENC_INDEX;
            rx_reg    <= I_SER_RX;
        end
    end

    // ==========================================================================
    // Step decoders
    // ==========================================================================
    svcp_step_type cmd_step;
    svcp_step_type enc_step;

    svcp_step_decode u_cmd_decode (
        .i_clk    (I_MCLK),
        .i_nrst   (I_NRST),
        .i_ce     (I_CE),
        .i_pins   ('{a: I_FEED_PULSE, b: I_FORWARD_PULSE}),
        .i_format (format_reg),
        .i_block  (I_DEVIATION_CLEAR),
        .o_step   (cmd_step)
    );

    // Encoder feedback always counts at full quadrature resolution.
    svcp_step_decode u_enc_decode (
        .i_clk    (I_MCLK),
        .i_nrst   (I_NRST),
        .i_ce     (I_CE),
        .i_pins   ('{a: I_ENC_A, b: I_ENC_B}),
        .i_format (FMT_QUAD_X4),
        .i_block  (1'b0),
        .o_step   (enc_step)
    );

    // ==========================================================================
    // Deviation counter
    // ==========================================================================
    logic signed [DEV_W-1:0] deviation_reg;
    logic signed [DEV_W-1:0] deviation_next;
    logic        [DEV_W-1:0] dev_mag;
    logic                    inpos_now;
    logic                    over_limit;

    always_comb begin
        deviation_next = deviation_reg;
        if (cmd_step.step && !clear_reg) begin
            deviation_next = cmd_step.fwd ? deviation_next + DEV_W'(1)
                                          : deviation_next - DEV_W'(1);
        end
        if (enc_step.step) begin
            deviation_next = enc_step.fwd ? deviation_next - DEV_W'(1)
                                          : deviation_next + DEV_W'(1);
        end
        if (clear_reg || I_DEVIATION_CLEAR) begin
            deviation_next = '0;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            deviation_reg <= '0;
        end else if (I_CE) begin
            deviation_reg <= deviation_next;
        end
    end

    assign dev_mag    = deviation_reg[DEV_W-1] ? DEV_W'(-deviation_reg)
                                               : DEV_W'(deviation_reg);
    assign inpos_now  = {{(DATA_W-DEV_W){1'b0}}, dev_mag} <= inpos_window_reg;
    assign over_limit = {{(DATA_W-DEV_W){1'b0}}, dev_mag} > ovf_limit_reg;

    // ==========================================================================
    // Command rate and clear length checks
    // ==========================================================================
    logic [TIMER_W-1:0] gap_cnt_reg;
    logic [TIMER_W-1:0] clear_cnt_reg;
    logic               rate_high;
    logic               short_clear;

    assign rate_high   = cmd_step.step && !clear_reg
                         && (gap_cnt_reg < TIMER_W'(RATE_MIN_CYC));
    assign short_clear = clear_reg && !I_DEVIATION_CLEAR
                         && (clear_cnt_reg < TIMER_W'(CLEAR_MIN_CYC));

    // The gap counter starts saturated so the first pulse after reset is never flagged.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            gap_cnt_reg <= '1;
        end else if (I_CE) begin
            if (cmd_step.step) begin
                gap_cnt_reg <= TIMER_W'(1);
            end else if (gap_cnt_reg != '1) begin
                gap_cnt_reg <= gap_cnt_reg + TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            clear_cnt_reg <= '0;
        end else if (I_CE) begin
            if (!I_DEVIATION_CLEAR) begin
                clear_cnt_reg <= '0;
            end else if (clear_cnt_reg != '1) begin
                clear_cnt_reg <= clear_cnt_reg + TIMER_W'(1);
            end
        end
    end

    // ==========================================================================
    // Alarm latch
    // ==========================================================================
    logic alarm_reg;
    logic alarm_cond;

    assign alarm_cond = I_FAULT_DETECT | over_limit;

    // A live fault wins over the reset input, so the alarm cannot be reset away.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            alarm_reg <= 1'b0;
        end else if (I_CE) begin
            if (alarm_cond) begin
                alarm_reg <= 1'b1;
            end else if (I_ALARM_RESET) begin
                alarm_reg <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Servo and brake sequence
    // ==========================================================================
    svcp_servo_type     servo_reg;
    logic [DATA_W-1:0]  brake_cnt_reg;
    logic               run_ok;

    assign run_ok = I_RUN & ~alarm_reg;

    // Power comes on first; the brake is released only after the delay so the
    // motor holds torque before the load is let go.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            servo_reg     <= SV_OFF;
            brake_cnt_reg <= '0;
        end else if (I_CE) begin
            case (servo_reg)
                SV_OFF: begin
                    brake_cnt_reg <= '0;
                    if (run_ok) begin
                        servo_reg <= SV_RELEASE;
                    end
                end
                SV_RELEASE: begin
                    brake_cnt_reg <= brake_cnt_reg + DATA_W'(1);
                    if (!run_ok) begin
                        servo_reg <= SV_OFF;
                    end else if (brake_cnt_reg >= brake_delay_reg) begin
                        servo_reg <= SV_ON;
                    end
                end
                SV_ON: begin
                    if (!run_ok) begin
                        servo_reg <= SV_OFF;
                    end
                end
                default: begin
                    servo_reg <= SV_OFF;
                end
            endcase
        end
    end

    // ==========================================================================
    // Pin outputs
    // ==========================================================================
    logic inpos_reg;

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            O_INDEX_PULSE_RETURN <= 1'b0;
            O_FAULT_OUT          <= 1'b1;
            O_BRAKE_INTERLOCK    <= 1'b0;
            O_IN_POSITION_OUT    <= 1'b0;
            O_SERVO_ON           <= 1'b0;
            O_SER_TX             <= 1'b1;
            inpos_reg            <= 1'b0;
        end else if (I_CE) begin
            O_INDEX_PULSE_RETURN <= index_reg;
            O_FAULT_OUT          <= ~(alarm_reg | alarm_cond);
            O_BRAKE_INTERLOCK    <= (servo_reg == SV_ON) && run_ok;
            O_IN_POSITION_OUT    <= inpos_now;
            O_SERVO_ON           <= (servo_reg != SV_OFF) && run_ok;
            O_SER_TX             <= tx_level_reg;
            inpos_reg            <= inpos_now;
        end
    end

    // ==========================================================================
    // Interrupts
    // ==========================================================================
    always_comb begin
        events                 = '0;
        events[EV_ALARM]       = alarm_cond & ~alarm_reg;
        events[EV_SHORT_CLEAR] = short_clear;
        events[EV_RATE_HIGH]   = rate_high;
        events[EV_INDEX]       = index_reg & ~O_INDEX_PULSE_RETURN;
        events[EV_INPOS_ENTER] = inpos_now & ~inpos_reg;
    end

    // A new event in the same cycle as its write-one-to-clear keeps the bit set.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            irq_status_reg <= '0;
        end else if (I_CE) begin
            if (wr_en && I_ADDR == OFS_IRQ_STATUS) begin
                irq_status_reg <= (irq_status_reg & ~I_WDATA[EV_W-1:0]) | events;
            end else begin
                irq_status_reg <= irq_status_reg | events;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_IRQ <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ==========================================================================
    // Read port
    // ==========================================================================
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        rdata_next = '0;
        case (I_ADDR)
            OFS_CTRL: begin
                rdata_next[CTRL_FMT_LSB +: CTRL_FMT_W] = format_reg;
                rdata_next[CTRL_TX_BIT]                = tx_level_reg;
            end
            OFS_INPOS_WINDOW: begin
                rdata_next = inpos_window_reg;
            end
            OFS_OVF_LIMIT: begin
                rdata_next = ovf_limit_reg;
            end
            OFS_BRAKE_DELAY: begin
                rdata_next = brake_delay_reg;
            end
            OFS_DEVIATION: begin
                rdata_next = {{(DATA_W-DEV_W){deviation_reg[DEV_W-1]}}, deviation_reg};
            end
            OFS_STATE: begin
                rdata_next[ST_SERVO_ON_BIT] = O_SERVO_ON;
                rdata_next[ST_ALARM_BIT]    = alarm_reg;
                rdata_next[ST_INPOS_BIT]    = O_IN_POSITION_OUT;
                rdata_next[ST_BRAKE_BIT]    = O_BRAKE_INTERLOCK;
                rdata_next[ST_RX_BIT]       = rx_reg;
                rdata_next[ST_CLEAR_BIT]    = clear_reg;
            end
            OFS_IRQ_STATUS: begin
                rdata_next[EV_W-1:0] = irq_status_reg;
            end
            OFS_IRQ_MASK: begin
                rdata_next[EV_W-1:0] = irq_mask_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read data stand for exactly the one cycle after the strobe.
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            O_RDATA <= '0;
        end else if (I_CE) begin
            O_RDATA <= rd_en ? rdata_next : '0;
        end
    end

endmodule : svcp_top

// *** svcp_top_assertions.sv ***
// Checker for the port behaviour of the servo command pulse block.
`timescale 1ns/1ps
module svcp_top_chk (
    // Watched ports
    input wire logic I_MCLK, I_NRST, I_RUN, I_ALARM_RESET, I_ENC_INDEX, I_FAULT_DETECT,
    input wire logic I_DEVIATION_CLEAR, O_INDEX_PULSE_RETURN, O_FAULT_OUT,
    input wire logic O_IN_POSITION_OUT, O_SERVO_ON, O_BRAKE_INTERLOCK
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    AST_INDEX_ECHO: assert property ($past(I_NRST) && $past(I_NRST, 2) |->
        O_INDEX_PULSE_RETURN == $past(I_ENC_INDEX, 2)) else $error("index echo wrong");
    AST_FAULT_LOW: assert property (I_FAULT_DETECT |=> !O_FAULT_OUT)
        else $error("fault output high on alarm");
    AST_ALARM_CLR: assert property ((I_ALARM_RESET && !I_FAULT_DETECT)[*2] |=> O_FAULT_OUT)
        else $error("alarm not cleared");
    AST_CLEAR_INPOS: assert property (I_DEVIATION_CLEAR[*3] |=> O_IN_POSITION_OUT)
        else $error("deviation not held at zero");
    AST_RUN_OFF: assert property (!I_RUN |=> !O_SERVO_ON)
        else $error("servo stays on");
    AST_RUN_ON: assert property ((I_RUN && O_FAULT_OUT && !I_FAULT_DETECT)[*3] |-> O_SERVO_ON)
        else $error("servo not on");
    AST_BRAKE_OFF: assert property (!I_RUN |=> !O_BRAKE_INTERLOCK)
        else $error("brake stays released");
    AST_BRAKE_SERVO: assert property (O_BRAKE_INTERLOCK |-> O_SERVO_ON)
        else $error("brake released while motor off");
endmodule : svcp_top_chk
bind svcp_top svcp_top_chk svcp_top_chk_inst (.I_MCLK, .I_NRST, .I_RUN, .I_ALARM_RESET,
    .I_ENC_INDEX, .I_FAULT_DETECT, .I_DEVIATION_CLEAR, .O_INDEX_PULSE_RETURN, .O_FAULT_OUT,
    .O_IN_POSITION_OUT, .O_SERVO_ON, .O_BRAKE_INTERLOCK);

// *** svcp_host_model.sv ***
// Host controller model that drives a pair of command pulse lines.
`timescale 1ns/1ps
module svcp_host_model (
    // Clock
    input  wire logic i_clk,
    // Pulse lines
    output logic      o_a = 1'b0,
    output logic      o_b = 1'b0
);
    // Lines go back low after a burst so the next format starts from a known level.
    task automatic send(input int fmt, input int n, input bit fwd, input int gap);
        bit e;
        bit m;
        for (int i = 0; i < n * (fmt < 2 ? 2 : 4); i++) begin
            e = i % 2 == 0;
            m = (i % 4 == 1) || (i % 4 == 2);
            @(posedge i_clk);
            if (fmt == 0) {o_a, o_b} <= {e, fwd};
            else if (fmt == 1) {o_a, o_b} <= fwd ? {1'b0, e} : {e, 1'b0};
            else {o_a, o_b} <= fwd ? {i % 4 < 2, m} : {m, i % 4 < 2};
            repeat (gap - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        {o_a, o_b} <= 2'b00;
    endtask : send
endmodule : svcp_host_model

// *** test_servo_command_pulse_io.sv ***
// Self-checking testbench of the servo command pulse I/O block.
`timescale 1ns/1ps
module test_servo_command_pulse_io;
    import svcp_pkg::*;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, run = 0, arst = 0, clr = 0, idx = 0, flt = 0;
    logic ca, cb, ea, eb, irq, zo, fo, bk, ip, so, tx;
    logic [7:0]  addr = 0;
    logic [31:0] wd = 0, rdat, v;
    int fails, cmp_count, e;
    int mul[5] = '{1, 1, 1, 2, 4};
    svcp_top svcp_top_inst (.I_MCLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_ADDR(addr),
        .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .O_IRQ(irq), .I_FEED_PULSE(ca),
        .I_FORWARD_PULSE(cb), .I_DEVIATION_CLEAR(clr), .I_RUN(run), .I_ALARM_RESET(arst),
        .I_ENC_A(ea), .I_ENC_B(eb), .I_ENC_INDEX(idx), .I_FAULT_DETECT(flt),
        .O_INDEX_PULSE_RETURN(zo), .O_FAULT_OUT(fo), .O_BRAKE_INTERLOCK(bk),
        .O_IN_POSITION_OUT(ip), .O_SERVO_ON(so), .I_SER_RX(tx), .O_SER_TX(tx));
    svcp_host_model host_inst (.i_clk(clk), .o_a(ca), .o_b(cb));
    svcp_host_model enc_inst (.i_clk(clk), .o_a(ea), .o_b(eb));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        #1 v = rdat & 32'h00FF_FFFF;
    endtask : acc
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        summarize();
    end
    initial begin
        void'($urandom(32'h0000_5d5e));
        repeat (16) @(posedge clk);
        nrst <= 1;
        acc(0, OFS_CTRL, 0);
        chk("ctrl", 32'h0000_0010, v);
        acc(1, OFS_CTRL, 0);
        @(posedge clk);
        #1 chk("serial tx", 0, tx);
        acc(0, OFS_STATE, 0);
        chk("state", 32'h0000_0004, v);
        acc(0, 8'h20, 0);
        chk("unmapped", 0, v);
        acc(1, OFS_INPOS_WINDOW, 0);
        for (int f = 0; f < 5; f++) begin
            bit d;
            d = $urandom_range(1);
            acc(1, OFS_CTRL, 32'h0000_0010 | f);
            host_inst.send(f, 2, d, RATE_MIN_CYC);
            e = (d ? 2 : -2) * mul[f];
            acc(0, OFS_DEVIATION, 0);
            chk("deviation", e & 32'h00FF_FFFF, v);
            chk("in position", 0, ip);
            clr <= 1;
            host_inst.send(f, 1, d, RATE_MIN_CYC);
            repeat (CLEAR_MIN_CYC) @(posedge clk);
            clr <= 0;
            repeat (4) @(posedge clk);
            acc(0, OFS_DEVIATION, 0);
            chk("cleared", 0, v);
            chk("in position", 1, ip);
        end
        enc_inst.send(FMT_QUAD_X4, 1, 1, 10);
        acc(0, OFS_DEVIATION, 0);
        chk("encoder", 32'h00FF_FFFC, v);
        acc(1, OFS_CTRL, 32'h0000_0010);
        acc(1, OFS_IRQ_MASK, 32'h0000_0004);
        host_inst.send(0, 2, 1, 4);
        acc(0, OFS_DEVIATION, 0);
        chk("fast pulses", 32'h00FF_FFFE, v);
        chk("irq", 1, irq);
        acc(1, OFS_IRQ_STATUS, 32'h0000_0004);
        @(posedge clk);
        #1 chk("irq", 0, irq);
        acc(1, OFS_BRAKE_DELAY, 5);
        run <= 1;
        repeat (20) @(posedge clk);
        chk("servo on", 1, so);
        chk("brake", 1, bk);
        flt <= 1;
        @(posedge clk);
        flt <= 0;
        repeat (3) @(posedge clk);
        chk("fault out", 0, fo);
        arst <= 1;
        repeat (3) @(posedge clk);
        arst <= 0;
        repeat (20) @(posedge clk);
        chk("fault out", 1, fo);
        run <= 0;
        idx <= 1;
        @(posedge clk);
        idx <= 0;
        @(posedge clk);
        #1 chk("index", 1, zo);
        chk("servo off", 0, so);
        summarize();
    end
endmodule : test_servo_command_pulse_io
